// ==== balance_expiry_timer_regs_bench.sv ====
`timescale 1ns/100ps
module balance_expiry_timer_regs_bench
  import bexp_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [BEXP_ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, time_unit, rsp;
  logic [BEXP_MODE_W-1:0] balancing_mode_select;
  logic [BEXP_EXP_W-1:0] master_expiry_time, cell_expiry_time_a, cell_expiry_time_b, em, ea, eb;
  logic [BEXP_NUM_TIMERS-1:0] timer_in_use, timer_expired, timer_forever;
  logic [31:0] rd;
  int error_cnt = 0;
  int cmp_count = 0;
  // 100 ns period
  always #50 aclk = ~aclk;
  bexp_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .balancing_mode_select(balancing_mode_select), .time_unit(time_unit),
    .master_expiry_time(master_expiry_time), .cell_expiry_time_a(cell_expiry_time_a),
    .cell_expiry_time_b(cell_expiry_time_b), .timer_in_use(timer_in_use), .timer_expired(timer_expired),
    .timer_forever(timer_forever));
  // byte address from a register index
  function automatic logic [BEXP_ADDR_W-1:0] adr(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction
  // one compare for every kind of value, zero extended
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // aw and w offered together, each released at its own handshake
  task automatic wr(input logic [BEXP_ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= s; wvalid <= 1'b1; bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (wvalid && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [BEXP_ADDR_W-1:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  // read back all three fields and their flags
  task automatic chk_all();
    rdr(adr(BEXP_IDX_MASTER)); chk("master", {22'h0, em}, rd);
    chk("master_out", {22'h0, em}, {22'h0, master_expiry_time});
    rdr(adr(BEXP_IDX_CELL_A)); chk("cell_a", {22'h0, ea}, rd);
    rdr(adr(BEXP_IDX_CELL_B)); chk("cell_b", {22'h0, eb}, rd);
    chk("cell_a_out", {22'h0, ea}, {22'h0, cell_expiry_time_a});
    chk("cell_b_out", {22'h0, eb}, {22'h0, cell_expiry_time_b});
    chk("expired", {29'h0, eb == 10'h0, ea == 10'h0, em == 10'h0}, {29'h0, timer_expired});
    chk("forever", {29'h0, &eb, &ea, &em}, {29'h0, timer_forever});
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard at 20000 cycles, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    logic [2:0] m;
    logic [1:0] eu;
    em = '0; ea = '0; eb = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_all();
    chk("unit_reset", 32'h0, {30'h0, time_unit});
    // mode off: everything writable, upper bits dropped, strobes per byte
    wr(adr(BEXP_IDX_MASTER), 32'hffff_fd55, 4'hf); em = 10'h155;
    chk("bresp_ok", {30'h0, BEXP_RESP_OKAY}, {30'h0, rsp});
    wr(adr(BEXP_IDX_MASTER), 32'h0000_03ff, 4'h1); em = 10'h1ff;
    wr(adr(BEXP_IDX_CELL_A), 32'h0000_03ff, 4'hf); ea = 10'h3ff;
    wr(adr(BEXP_IDX_CELL_B), 32'h0000_02aa, 4'hf); eb = 10'h2aa;
    chk_all();
    wr(adr(BEXP_IDX_MASTER), 32'h0000_03ff, 4'hf); em = 10'h3ff;
    chk_all();
    // every mode code from 1 to 7: unit, timer use and write blocking
    for (int i = 1; i < 8; i++) begin
      m = 3'(i);
      wr(adr(BEXP_IDX_MODE), {29'h0, m}, 4'h1);
      case (m)
        3'h1, 3'h4: eu = BEXP_UNIT_SEC;
        3'h2, 3'h5: eu = BEXP_UNIT_MIN;
        default: eu = BEXP_UNIT_HOUR;
      endcase
      chk("unit", {30'h0, eu}, {30'h0, time_unit});
      chk("in_use", (m inside {3'h4, 3'h5, 3'h6}) ? 32'h6 : 32'h1, {29'h0, timer_in_use});
      chk("mode", {29'h0, m}, {29'h0, balancing_mode_select});
      rdr(adr(BEXP_IDX_MODE));
      chk("mode_read", {29'h0, m}, rd);
      wr(adr(BEXP_IDX_MASTER), {22'h0, 7'h0, m}, 4'hf);
      chk("blocked_resp", {30'h0, BEXP_RESP_OKAY}, {30'h0, rsp});
      wr(adr(BEXP_IDX_CELL_A), {22'h0, 7'h40, m}, 4'hf);
      wr(adr(BEXP_IDX_CELL_B), {22'h0, 7'h0, m}, 4'hf);
      if (!m[BEXP_MODE_AUTO_BIT]) begin
        ea = {7'h40, m};
        eb = {7'h0, m};
      end
      chk_all();
    end
    // back to off: master writable again, zero means expired
    wr(adr(BEXP_IDX_MODE), 32'h0, 4'h1);
    chk("unit_off", {30'h0, BEXP_UNIT_NONE}, {30'h0, time_unit});
    chk("in_use_off", 32'h0, {29'h0, timer_in_use});
    wr(adr(BEXP_IDX_MASTER), 32'h0, 4'hf); em = 10'h0;
    chk_all();
    // unmapped and misaligned places
    rdr(12'h000);
    chk("unmapped_resp", {30'h0, BEXP_RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped_data", 32'h0, rd);
    wr(adr(BEXP_IDX_CELL_A) + 12'h1, 32'h0000_0111, 4'hf);
    chk("misaligned_resp", {30'h0, BEXP_RESP_SLVERR}, {30'h0, rsp});
    chk_all();
    // cell a set to run forever, then an individual mode makes that timer live
    wr(adr(BEXP_IDX_CELL_A), 32'h0000_03ff, 4'hf);
    ea = 10'h3ff;
    wr(adr(BEXP_IDX_MODE), 32'h0000_0005, 4'h1);
    chk("in_use_indiv", 32'h6, {29'h0, timer_in_use});
    chk_all();
    // second reset mid-run clears the fields and the mode
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    ea = '0; eb = '0;
    chk_all();
    chk("mode_reset", 32'h0, {29'h0, balancing_mode_select});
    chk("in_use_reset", 32'h0, {29'h0, timer_in_use});
    chk("unit_reset2", 32'h0, {30'h0, time_unit});
    give_verdict();
  end
endmodule

// ==== bexp_pkg.sv ====
package bexp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] BEXP_IDX_MASTER = 8'h70;
  localparam logic [7:0] BEXP_IDX_CELL_A = 8'h71;
  localparam logic [7:0] BEXP_IDX_CELL_B = 8'h72;
  localparam logic [7:0] BEXP_IDX_MODE = 8'h7f;
  localparam int BEXP_ADDR_W = 12;
  localparam int BEXP_EXP_W = 10;
  localparam int BEXP_MODE_W = 3;
  localparam int BEXP_NUM_TIMERS = 3;
  // timer slot order in the flag vectors
  localparam int BEXP_SLOT_MASTER = 0;
  localparam int BEXP_SLOT_CELL_A = 1;
  localparam int BEXP_SLOT_CELL_B = 2;
  // reset values and special codes
  localparam logic [9:0] BEXP_EXP_RESET = 10'h000;
  localparam logic [9:0] BEXP_EXP_EXPIRED = 10'h000;
  localparam logic [9:0] BEXP_EXP_FOREVER = 10'h3ff;
  localparam logic [2:0] BEXP_MODE_RESET = 3'h0;
  // balancing mode codes
  localparam logic [2:0] BEXP_MODE_OFF = 3'h0;
  localparam logic [2:0] BEXP_MODE_MANUAL_S = 3'h1;
  localparam logic [2:0] BEXP_MODE_MANUAL_M = 3'h2;
  localparam logic [2:0] BEXP_MODE_DISCHARGE = 3'h3;
  localparam logic [2:0] BEXP_MODE_INDIV_S = 3'h4;
  localparam logic [2:0] BEXP_MODE_INDIV_M = 3'h5;
  localparam logic [2:0] BEXP_MODE_INDIV_H = 3'h6;
  localparam logic [2:0] BEXP_MODE_GROUP = 3'h7;
  localparam int BEXP_MODE_AUTO_BIT = 2;
  // time unit of one count
  localparam logic [1:0] BEXP_UNIT_NONE = 2'h0;
  localparam logic [1:0] BEXP_UNIT_SEC = 2'h1;
  localparam logic [1:0] BEXP_UNIT_MIN = 2'h2;
  localparam logic [1:0] BEXP_UNIT_HOUR = 2'h3;
  // axi responses
  localparam logic [1:0] BEXP_RESP_OKAY = 2'h0;
  localparam logic [1:0] BEXP_RESP_SLVERR = 2'h2;
endpackage

// ==== bexp_regs.sv ====
`timescale 1ns/100ps
module bexp_regs
  import bexp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [BEXP_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [BEXP_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // to the balancing engine
  output logic [BEXP_MODE_W-1:0] balancing_mode_select,
  output logic [1:0] time_unit,
  output logic [BEXP_EXP_W-1:0] master_expiry_time,
  output logic [BEXP_EXP_W-1:0] cell_expiry_time_a,
  output logic [BEXP_EXP_W-1:0] cell_expiry_time_b,
  output logic [BEXP_NUM_TIMERS-1:0] timer_in_use,
  output logic [BEXP_NUM_TIMERS-1:0] timer_expired,
  output logic [BEXP_NUM_TIMERS-1:0] timer_forever
);

  // bus handshake state
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [BEXP_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_write;
  // register state
  logic [BEXP_MODE_W-1:0] mode_q, mode_d;
  logic [BEXP_EXP_W-1:0] exp_q [BEXP_NUM_TIMERS];
  logic [BEXP_EXP_W-1:0] exp_d [BEXP_NUM_TIMERS];
  logic [1:0] unit_q, unit_d;
  logic [BEXP_NUM_TIMERS-1:0] use_q, use_d, zero_q, zero_d, ever_q, ever_d;
  logic master_open, cell_open, indiv_d;

  // every check below runs on the bus clock and rests while reset is held
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // merge written bytes into a 10-bit field; upper bits of the word are dropped
  function automatic logic [BEXP_EXP_W-1:0] merge(input logic [BEXP_EXP_W-1:0] old,
                                                  input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [7:0] word_idx(input logic [BEXP_ADDR_W-1:0] a);
    word_idx = a[9:2];
  endfunction

  function automatic logic idx_ok(input logic [BEXP_ADDR_W-1:0] a);
    idx_ok = (a[1:0] == 2'h0) && (a[BEXP_ADDR_W-1:10] == 2'h0) &&
             (word_idx(a) == BEXP_IDX_MASTER || word_idx(a) == BEXP_IDX_CELL_A ||
              word_idx(a) == BEXP_IDX_CELL_B || word_idx(a) == BEXP_IDX_MODE);
  endfunction

  // write gates depend on the mode currently in force
  assign master_open = (mode_q == BEXP_MODE_OFF);
  assign cell_open = !mode_q[BEXP_MODE_AUTO_BIT];
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

  // write channel: address and data are caught in either order, response after both
  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      awaddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_hold_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = idx_ok(awaddr_q) ? BEXP_RESP_OKAY : BEXP_RESP_SLVERR; // blocked writes still answer okay
    end else if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
  end

  // register updates; a refused write leaves the stored value untouched
  always_comb begin
    mode_d = mode_q;
    for (int i = 0; i < BEXP_NUM_TIMERS; i++) begin
      exp_d[i] = exp_q[i];
    end
    if (do_write && idx_ok(awaddr_q)) begin
      unique case (word_idx(awaddr_q))
        BEXP_IDX_MASTER: if (master_open) exp_d[BEXP_SLOT_MASTER] =
          merge(exp_q[BEXP_SLOT_MASTER], wdata_q, wstrb_q);
        BEXP_IDX_CELL_A: if (cell_open) exp_d[BEXP_SLOT_CELL_A] =
          merge(exp_q[BEXP_SLOT_CELL_A], wdata_q, wstrb_q);
        BEXP_IDX_CELL_B: if (cell_open) exp_d[BEXP_SLOT_CELL_B] =
          merge(exp_q[BEXP_SLOT_CELL_B], wdata_q, wstrb_q);
        default: if (wstrb_q[0]) mode_d = wdata_q[BEXP_MODE_W-1:0];
      endcase
    end
  end

  // read channel: one request at a time, data one cycle after the address
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = idx_ok(araddr) ? BEXP_RESP_OKAY : BEXP_RESP_SLVERR;
      rdata_d = 32'h0; // upper bits always read zero
      if (idx_ok(araddr)) begin
        unique case (word_idx(araddr))
          BEXP_IDX_MASTER: rdata_d[BEXP_EXP_W-1:0] = exp_q[BEXP_SLOT_MASTER];
          BEXP_IDX_CELL_A: rdata_d[BEXP_EXP_W-1:0] = exp_q[BEXP_SLOT_CELL_A];
          BEXP_IDX_CELL_B: rdata_d[BEXP_EXP_W-1:0] = exp_q[BEXP_SLOT_CELL_B];
          default: rdata_d[BEXP_MODE_W-1:0] = mode_q;
        endcase
      end
    end else if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  // unit and timer selection follow the next mode so they line up with the registers
  always_comb begin
    unique case (mode_d)
      BEXP_MODE_MANUAL_S, BEXP_MODE_INDIV_S: unit_d = BEXP_UNIT_SEC;
      BEXP_MODE_MANUAL_M, BEXP_MODE_INDIV_M: unit_d = BEXP_UNIT_MIN;
      BEXP_MODE_DISCHARGE, BEXP_MODE_INDIV_H, BEXP_MODE_GROUP: unit_d = BEXP_UNIT_HOUR;
      default: unit_d = BEXP_UNIT_NONE;
    endcase
    indiv_d = mode_d[BEXP_MODE_AUTO_BIT] && (mode_d != BEXP_MODE_GROUP);
    use_d[BEXP_SLOT_MASTER] = (mode_d != BEXP_MODE_OFF) && !indiv_d; // watchdog for non-individual modes
  end

  // per-timer decode; each cell slot drives only its own switch
  for (genvar g = 0; g < BEXP_NUM_TIMERS; g++) begin : g_tmr
    always_comb begin
      zero_d[g] = (exp_d[g] == BEXP_EXP_EXPIRED); // zero counts as already run out
      ever_d[g] = (exp_d[g] == BEXP_EXP_FOREVER); // no expiry ever
    end
    if (g != BEXP_SLOT_MASTER) begin : g_cell
      // procedural like the master bit, so the vector never mixes driver kinds
      always_comb begin
        use_d[g] = indiv_d; // cell timers only in individual automated modes
      end
    end
  end

  // all state is registered here; reset gives zero expiries, hence balancing disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= BEXP_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= BEXP_RESP_OKAY;
      mode_q <= BEXP_MODE_RESET;
      for (int i = 0; i < BEXP_NUM_TIMERS; i++) begin
        exp_q[i] <= BEXP_EXP_RESET;
      end
      unit_q <= BEXP_UNIT_NONE;
      use_q <= '0;
      zero_q <= '1;
      ever_q <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      mode_q <= mode_d;
      exp_q <= exp_d;
      unit_q <= unit_d;
      use_q <= use_d;
      zero_q <= zero_d;
      ever_q <= ever_d;
    end
  end

  // outputs straight from flops
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign balancing_mode_select = mode_q;
  assign time_unit = unit_q;
  assign master_expiry_time = exp_q[BEXP_SLOT_MASTER];
  assign cell_expiry_time_a = exp_q[BEXP_SLOT_CELL_A];
  assign cell_expiry_time_b = exp_q[BEXP_SLOT_CELL_B];
  assign timer_in_use = use_q;
  assign timer_expired = zero_q;
  assign timer_forever = ever_q;

  // write locks look at the mode in force when the write lands
  master_lock_a: assert property (do_write && word_idx(awaddr_q) == BEXP_IDX_MASTER && !master_open
    |=> $stable(master_expiry_time)) else $error("master expiry changed while balancing");
  cell_lock_a: assert property (do_write && word_idx(awaddr_q) == BEXP_IDX_CELL_A && !cell_open
    |=> $stable(cell_expiry_time_a)) else $error("cell expiry changed in auto mode");
  cell_write_a: assert property (do_write && idx_ok(awaddr_q) && word_idx(awaddr_q) == BEXP_IDX_CELL_B
    && cell_open && wstrb_q == 4'hf |=> cell_expiry_time_b == $past(wdata_q[BEXP_EXP_W-1:0]))
    else $error("cell b write lost");
  upper_zero_a: assert property (rvalid |-> rdata[31:BEXP_EXP_W] == 22'h0) else $error("upper bits not zero");
  forever_flag_a: assert property (
    timer_forever[BEXP_SLOT_MASTER] == (master_expiry_time == BEXP_EXP_FOREVER)) else $error("forever flag wrong");
  expired_flag_a: assert property (
    timer_expired[BEXP_SLOT_CELL_A] == (cell_expiry_time_a == BEXP_EXP_EXPIRED)) else $error("expired flag wrong");
  watchdog_use_a: assert property (timer_in_use[BEXP_SLOT_MASTER] |-> balancing_mode_select != BEXP_MODE_OFF
    && timer_in_use[BEXP_SLOT_CELL_A] == 1'b0) else $error("watchdog used in wrong mode");
  cell_use_a: assert property (timer_in_use[BEXP_SLOT_CELL_B] |-> balancing_mode_select[BEXP_MODE_AUTO_BIT])
    else $error("cell timer used outside auto mode");
  // read data is loaded on the handshake, so only the valid and the busy ready are checked here
  read_latency_a: assert property (arvalid && arready |=> rvalid && !arready) else $error("read late");
  write_resp_a: assert property (do_write |=> bvalid) else $error("write response late");
  blocked_write_c: cover property (do_write && mode_q != BEXP_MODE_OFF);
  forever_seen_c: cover property (timer_forever[BEXP_SLOT_CELL_A] && timer_in_use[BEXP_SLOT_CELL_A]);
  read_back_c: cover property (bvalid ##[1:8] rvalid);
endmodule
